/* File: shared/lsimm_pkg.sv */
package lsimm_pkg;

	// ==========================================================
	// Register numbers and widths
	localparam logic [3:0]  REG_SP       = 4'hD;
	localparam logic [3:0]  REG_PC       = 4'hF;
	localparam int          IMM_W        = 12;

	// ==========================================================
	// Offset limits, as magnitudes of the 12-bit immediate
	localparam logic [11:0] OFS_SUB_MAX  = 12'h0FF;
	localparam logic [11:0] OFS_IDX_MAX  = 12'h0FF;
	localparam logic [11:0] OFS_DUAL_MAX = 12'h3FC;
	localparam logic [31:0] DUAL_STEP    = 32'h0000_0004;

	// ==========================================================
	// Operation encodings
	typedef enum logic [1:0] {
		LSIMM_OP_ADR   = 2'h0,
		LSIMM_OP_LOAD  = 2'h1,
		LSIMM_OP_STORE = 2'h2
	} lsimm_op_t;

	typedef enum logic [1:0] {
		LSIMM_SZ_BYTE = 2'h0,
		LSIMM_SZ_HALF = 2'h1,
		LSIMM_SZ_WORD = 2'h2,
		LSIMM_SZ_DUAL = 2'h3
	} lsimm_size_t;

	typedef enum logic [1:0] {
		LSIMM_MD_OFFSET = 2'h0,
		LSIMM_MD_PRE    = 2'h1,
		LSIMM_MD_POST   = 2'h2
	} lsimm_mode_t;

	// ==========================================================
	// Register restriction check shared by both ends
	function automatic logic lsimm_regs_ok(input lsimm_op_t op, input lsimm_size_t sz,
		input lsimm_mode_t md, input logic [3:0] rt, input logic [3:0] rt2,
		input logic [3:0] rn);
		logic ok;
		logic wb;
		ok = 1'b1;
		wb = (md != LSIMM_MD_OFFSET);
		case (op)
			LSIMM_OP_ADR: begin
				ok = (rt != REG_SP) && (rt != REG_PC);
			end
			LSIMM_OP_LOAD: begin
				if ((rt == REG_SP || rt == REG_PC) && sz != LSIMM_SZ_WORD) ok = 1'b0;
				if (sz == LSIMM_SZ_DUAL && (rt2 == REG_SP || rt2 == REG_PC || rt == rt2))
					ok = 1'b0;
				if (wb && (rn == rt || (sz == LSIMM_SZ_DUAL && rn == rt2))) ok = 1'b0;
			end
			LSIMM_OP_STORE: begin
				if (rt == REG_SP && sz != LSIMM_SZ_WORD) ok = 1'b0;
				if (rt == REG_PC || rn == REG_PC) ok = 1'b0;
				if (sz == LSIMM_SZ_DUAL && rt2 == REG_PC) ok = 1'b0;
				if (wb && (rn == rt || (sz == LSIMM_SZ_DUAL && rn == rt2))) ok = 1'b0;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

endpackage

/* File: shared/lsimm_if.sv */
`timescale 1ns/1ps
interface lsimm_if;
	import lsimm_pkg::*;

	// ==========================================================
	// Request from the issuing end
	logic              req_valid;
	logic              req_ready;
	lsimm_op_t         req_op;
	lsimm_size_t       req_size;
	logic              req_signed;
	lsimm_mode_t       req_mode;
	logic              req_add;
	logic [IMM_W-1:0]  req_imm;
	logic [3:0]        req_rt;
	logic [3:0]        req_rt2;
	logic [3:0]        req_rn;
	logic [31:0]       req_base;
	logic [31:0]       req_pc;
	logic [31:0]       req_wdata;
	logic [31:0]       req_wdata2;

	// ==========================================================
	// Memory beats
	logic              mem_valid;
	logic              mem_write;
	logic [31:0]       mem_addr;
	lsimm_size_t       mem_size;
	logic [31:0]       mem_wdata;
	logic              mem_done;
	logic [31:0]       mem_rdata;

	modport dev (
		input  req_valid, req_op, req_size, req_signed, req_mode, req_add, req_imm,
		input  req_rt, req_rt2, req_rn, req_base, req_pc, req_wdata, req_wdata2,
		input  mem_done, mem_rdata,
		output req_ready, mem_valid, mem_write, mem_addr, mem_size, mem_wdata
	);

	modport iss (
		output req_valid, req_op, req_size, req_signed, req_mode, req_add, req_imm,
		output req_rt, req_rt2, req_rn, req_base, req_pc, req_wdata, req_wdata2,
		output mem_done, mem_rdata,
		input  req_ready, mem_valid, mem_write, mem_addr, mem_size, mem_wdata
	);
endinterface

/* File: logic/lsimm_dev.sv */
// Summary of operation
// - Address form writes program counter plus immediate.
// - Address form reaches minus to plus 4095.
// - Address form never targets stack pointer, counter.
// - Address form leaves condition flags untouched.
// - Narrow loads widen by zero or sign fill.
// - Loads and stores move one or two registers.
// - Missing offset means address equals base.
// - Offset mode uses base plus offset, no write-back.
// - Pre-index accesses and writes back base plus offset.
// - Post-index accesses base, then updates it.
// - Single offsets: -255..4095 plain, -255..255 indexed.
// - Indexed pairs: multiples of four up to 1020.
// - Stack pointer or counter targets only word loads.
// - Pair loads name two distinct registers.
// - Write-back base differs from transfer registers.
// - Counter load needs bit0 set; branch clears it.
// - Conditional counter load ends its conditional block.
// - Stores: stack pointer only word, never counter; code still accepts stack pointer as pair rt2.
`timescale 1ns/1ps
module lsimm_dev
	import lsimm_pkg::*;
(
	// Clock and reset
	input  wire logic          I_CLOCK,
	input  wire logic          I_RESET,
	// Link to the issuing end
	lsimm_if.dev               LINK,
	// Register file results
	output logic               O_RES_VALID,
	output logic [3:0]         O_RES_REG,
	output logic [31:0]        O_RES_DATA,
	// Base write-back
	output logic               O_WB_VALID,
	output logic [3:0]         O_WB_REG,
	output logic [31:0]        O_WB_DATA,
	// Branch and refusal
	output logic               O_BRANCH_VALID,
	output logic [31:0]        O_BRANCH_TARGET,
	output logic               O_FAULT
);
	import lsimm_pkg::*;

	// ==========================================================
	// State
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} lsimm_dev_st_t;

	typedef struct packed {
		lsimm_dev_st_t st;
		lsimm_op_t     op;
		lsimm_size_t   size;
		logic          sgn;
		logic [3:0]    rt;
		logic [3:0]    rt2;
		logic [3:0]    rn;
		logic          wb_en;
		logic [31:0]   wb_val;
		logic [31:0]   wdata2;
		logic          beat;
		logic          ready;
		logic          mem_valid;
		logic          mem_write;
		logic [31:0]   mem_addr;
		lsimm_size_t   mem_size;
		logic [31:0]   mem_wdata;
		logic          res_valid;
		logic [3:0]    res_reg;
		logic [31:0]   res_data;
		logic          wb_valid;
		logic [3:0]    wb_reg;
		logic [31:0]   wb_data;
		logic          br_valid;
		logic [31:0]   br_target;
		logic          fault;
	} lsimm_dev_s_t;

	lsimm_dev_s_t s;
	lsimm_dev_s_t next_s;

	// ==========================================================
	// Helpers
	function automatic logic ofs_ok(input lsimm_op_t op, input lsimm_size_t sz,
		input lsimm_mode_t md, input logic add, input logic [IMM_W-1:0] imm);
		logic ok;
		ok = 1'b1;
		if (op == LSIMM_OP_ADR) begin
			ok = 1'b1;
		end else if (sz == LSIMM_SZ_DUAL) begin
			ok = (imm[1:0] == 2'h0) && (imm <= OFS_DUAL_MAX);
		end else if (md == LSIMM_MD_OFFSET) begin
			ok = add || (imm <= OFS_SUB_MAX);
		end else begin
			ok = imm <= OFS_IDX_MAX;
		end
		return ok;
	endfunction

	function automatic logic [31:0] widen(input logic [31:0] d, input lsimm_size_t sz,
		input logic sgn);
		logic [31:0] r;
		r = d;
		case (sz)
			LSIMM_SZ_BYTE: begin
				r = sgn ? {{24{d[7]}}, d[7:0]} : {24'h000000, d[7:0]};
			end
			LSIMM_SZ_HALF: begin
				r = sgn ? {{16{d[15]}}, d[15:0]} : {16'h0000, d[15:0]};
			end
			default: begin
				r = d;
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// Next state
	logic [31:0] ofs;
	logic [31:0] sum;
	logic [31:0] ld_val;
	logic        req_ok;

	always_comb begin
		next_s = s;
		next_s.mem_valid = 1'b0;
		next_s.res_valid = 1'b0;
		next_s.wb_valid = 1'b0;
		next_s.br_valid = 1'b0;
		next_s.fault = 1'b0;
		// An absent offset is a zero immediate, so the sum is the base itself.
		ofs = LINK.req_add ? {20'h00000, LINK.req_imm} : 32'h0 - {20'h00000, LINK.req_imm};
		sum = LINK.req_base + ofs;
		ld_val = widen(LINK.mem_rdata, s.size, s.sgn);
		req_ok = ofs_ok(LINK.req_op, LINK.req_size, LINK.req_mode, LINK.req_add, LINK.req_imm)
			&& lsimm_regs_ok(LINK.req_op, LINK.req_size, LINK.req_mode,
			LINK.req_rt, LINK.req_rt2, LINK.req_rn);
		case (s.st)
			ST_IDLE: begin
				if (LINK.req_valid && s.ready) begin
					if (!req_ok) begin
						next_s.fault = 1'b1;
					end else if (LINK.req_op == LSIMM_OP_ADR) begin
						// No flag state is kept or driven here at all.
						next_s.res_valid = 1'b1;
						next_s.res_reg = LINK.req_rt;
						next_s.res_data = LINK.req_pc + ofs;
					end else begin
						next_s.ready = 1'b0;
						next_s.st = ST_WAIT;
						next_s.op = LINK.req_op;
						next_s.size = LINK.req_size;
						next_s.sgn = LINK.req_signed && (LINK.req_op == LSIMM_OP_LOAD);
						next_s.rt = LINK.req_rt;
						next_s.rt2 = LINK.req_rt2;
						next_s.rn = LINK.req_rn;
						next_s.wb_en = LINK.req_mode != LSIMM_MD_OFFSET;
						next_s.wb_val = sum;
						next_s.wdata2 = LINK.req_wdata2;
						next_s.beat = 1'b0;
						next_s.mem_valid = 1'b1;
						next_s.mem_write = LINK.req_op == LSIMM_OP_STORE;
						// Post-index reaches memory at the untouched base.
						next_s.mem_addr = (LINK.req_mode == LSIMM_MD_POST) ?
							LINK.req_base : sum;
						next_s.mem_size = (LINK.req_size == LSIMM_SZ_DUAL) ?
							LSIMM_SZ_WORD : LINK.req_size;
						next_s.mem_wdata = LINK.req_wdata;
					end
				end
			end
			ST_WAIT: begin
				if (LINK.mem_done) begin
					if (s.op == LSIMM_OP_LOAD) begin
						if (s.size == LSIMM_SZ_WORD && s.rt == REG_PC) begin
							next_s.br_valid = 1'b1;
							next_s.br_target = {LINK.mem_rdata[31:1], 1'b0};
						end else begin
							next_s.res_valid = 1'b1;
							next_s.res_reg = s.beat ? s.rt2 : s.rt;
							next_s.res_data = ld_val;
						end
					end
					if (s.size == LSIMM_SZ_DUAL && !s.beat) begin
						next_s.beat = 1'b1;
						next_s.mem_valid = 1'b1;
						next_s.mem_addr = s.mem_addr + DUAL_STEP;
						next_s.mem_wdata = s.wdata2;
					end else begin
						next_s.st = ST_IDLE;
						next_s.ready = 1'b1;
						next_s.wb_valid = s.wb_en;
						next_s.wb_reg = s.rn;
						next_s.wb_data = s.wb_val;
					end
				end
			end
			default: begin
				next_s.st = ST_IDLE;
				next_s.ready = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign LINK.req_ready = s.ready;
	assign LINK.mem_valid = s.mem_valid;
	assign LINK.mem_write = s.mem_write;
	assign LINK.mem_addr = s.mem_addr;
	assign LINK.mem_size = s.mem_size;
	assign LINK.mem_wdata = s.mem_wdata;
	assign O_RES_VALID = s.res_valid;
	assign O_RES_REG = s.res_reg;
	assign O_RES_DATA = s.res_data;
	assign O_WB_VALID = s.wb_valid;
	assign O_WB_REG = s.wb_reg;
	assign O_WB_DATA = s.wb_data;
	assign O_BRANCH_VALID = s.br_valid;
	assign O_BRANCH_TARGET = s.br_target;
	assign O_FAULT = s.fault;
endmodule

/* File: logic/lsimm_iss.sv */
`timescale 1ns/1ps
module lsimm_iss
	import lsimm_pkg::*;
(
	// Clock and reset
	input  wire logic             I_CLOCK,
	input  wire logic             I_RESET,
	// Link to the decoding end
	lsimm_if.iss                  LINK,
	// Instruction in
	input  wire logic             I_VALID,
	input  wire lsimm_pkg::lsimm_op_t   I_OP,
	input  wire lsimm_pkg::lsimm_size_t I_SIZE,
	input  wire logic             I_SIGNED,
	input  wire lsimm_pkg::lsimm_mode_t I_MODE,
	input  wire logic             I_ADD,
	input  wire logic [11:0]      I_IMM,
	input  wire logic [3:0]       I_RT,
	input  wire logic [3:0]       I_RT2,
	input  wire logic [3:0]       I_RN,
	input  wire logic [31:0]      I_BASE,
	input  wire logic [31:0]      I_PC,
	input  wire logic [31:0]      I_WDATA,
	input  wire logic [31:0]      I_WDATA2,
	input  wire logic             I_IN_BLOCK,
	input  wire logic             I_BLOCK_LAST,
	// Issue status
	output logic                  O_READY,
	output logic                  O_REJECT,
	output logic                  O_BAD_TARGET,
	// Memory system
	output logic                  O_MEM_VALID,
	output logic                  O_MEM_WRITE,
	output logic [31:0]           O_MEM_ADDR,
	output lsimm_pkg::lsimm_size_t O_MEM_SIZE,
	output logic [31:0]           O_MEM_WDATA,
	input  wire logic             I_MEM_DONE,
	input  wire logic [31:0]      I_MEM_RDATA
);
	import lsimm_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic          ready;
		logic          req_valid;
		lsimm_op_t     op;
		lsimm_size_t   size;
		logic          sgn;
		lsimm_mode_t   mode;
		logic          add;
		logic [11:0]   imm;
		logic [3:0]    rt;
		logic [3:0]    rt2;
		logic [3:0]    rn;
		logic [31:0]   base;
		logic [31:0]   pc;
		logic [31:0]   wdata;
		logic [31:0]   wdata2;
		logic          pc_load;
		logic          reject;
		logic          bad_target;
		logic          mem_valid;
		logic          mem_write;
		logic [31:0]   mem_addr;
		lsimm_size_t   mem_size;
		logic [31:0]   mem_wdata;
		logic          mem_done;
		logic [31:0]   mem_rdata;
	} lsimm_iss_s_t;

	lsimm_iss_s_t s;
	lsimm_iss_s_t next_s;
	logic         legal;
	logic         pc_word;

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.reject = 1'b0;
		pc_word = (I_OP == LSIMM_OP_LOAD) && (I_SIZE == LSIMM_SZ_WORD) && (I_RT == REG_PC);
		legal = lsimm_regs_ok(I_OP, I_SIZE, I_MODE, I_RT, I_RT2, I_RN)
			&& !(pc_word && I_IN_BLOCK && !I_BLOCK_LAST);
		if (s.req_valid && LINK.req_ready) begin
			next_s.req_valid = 1'b0;
			next_s.ready = 1'b1;
		end else if (!s.req_valid && s.ready && I_VALID) begin
			if (!legal) begin
				next_s.reject = 1'b1;
			end else begin
				next_s.ready = 1'b0;
				next_s.req_valid = 1'b1;
				next_s.op = I_OP;
				next_s.size = I_SIZE;
				next_s.sgn = I_SIGNED;
				next_s.mode = I_MODE;
				next_s.add = I_ADD;
				next_s.imm = I_IMM;
				next_s.rt = I_RT;
				next_s.rt2 = I_RT2;
				next_s.rn = I_RN;
				next_s.base = I_BASE;
				next_s.pc = I_PC;
				next_s.wdata = I_WDATA;
				next_s.wdata2 = I_WDATA2;
				next_s.pc_load = pc_word;
			end
		end
		// The memory path is retimed one cycle each way to keep every port on a flop.
		next_s.mem_valid = LINK.mem_valid;
		next_s.mem_write = LINK.mem_write;
		next_s.mem_addr = LINK.mem_addr;
		next_s.mem_size = LINK.mem_size;
		next_s.mem_wdata = LINK.mem_wdata;
		next_s.mem_done = I_MEM_DONE;
		next_s.mem_rdata = I_MEM_RDATA;
		next_s.bad_target = I_MEM_DONE && s.pc_load && !I_MEM_RDATA[0];
	end

	// ==========================================================
	// Registers
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			s <= '0;
			s.ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign LINK.req_valid = s.req_valid;
	assign LINK.req_op = s.op;
	assign LINK.req_size = s.size;
	assign LINK.req_signed = s.sgn;
	assign LINK.req_mode = s.mode;
	assign LINK.req_add = s.add;
	assign LINK.req_imm = s.imm;
	assign LINK.req_rt = s.rt;
	assign LINK.req_rt2 = s.rt2;
	assign LINK.req_rn = s.rn;
	assign LINK.req_base = s.base;
	assign LINK.req_pc = s.pc;
	assign LINK.req_wdata = s.wdata;
	assign LINK.req_wdata2 = s.wdata2;
	assign LINK.mem_done = s.mem_done;
	assign LINK.mem_rdata = s.mem_rdata;
	assign O_READY = s.ready;
	assign O_REJECT = s.reject;
	assign O_BAD_TARGET = s.bad_target;
	assign O_MEM_VALID = s.mem_valid;
	assign O_MEM_WRITE = s.mem_write;
	assign O_MEM_ADDR = s.mem_addr;
	assign O_MEM_SIZE = s.mem_size;
	assign O_MEM_WDATA = s.mem_wdata;
endmodule

/* File: tb/lsimm_props.sv */
`timescale 1ns/1ps
module lsimm_props
	import lsimm_pkg::*;
(
	// Clock and reset
	input wire logic                  I_CLOCK,
	input wire logic                  I_RESET,
	// Request side
	input wire logic                  req_valid,
	input wire logic                  req_ready,
	input wire lsimm_pkg::lsimm_op_t   req_op,
	input wire lsimm_pkg::lsimm_size_t req_size,
	input wire lsimm_pkg::lsimm_mode_t req_mode,
	input wire logic                  req_add,
	input wire logic [IMM_W-1:0]      req_imm,
	input wire logic [31:0]           req_base,
	input wire logic [31:0]           req_wdata,
	// Memory side
	input wire logic                  mem_valid,
	input wire logic                  mem_write,
	input wire logic [31:0]           mem_addr,
	input wire lsimm_pkg::lsimm_size_t mem_size,
	input wire logic [31:0]           mem_wdata,
	input wire logic                  mem_done
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);
	// ==========================================================
	// Helper state: which beat of a pair is outstanding.
	logic        take;
	logic        ls;
	logic [31:0] ofs_a;
	logic        dual;
	logic [1:0]  beats;
	logic [31:0] last_addr;
	assign take  = req_valid && req_ready;
	assign ls    = take && (req_op != LSIMM_OP_ADR);
	assign ofs_a = req_add ? req_base + 32'(req_imm) : req_base - 32'(req_imm);
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			dual      <= 1'b0;
			beats     <= 2'h0;
			last_addr <= 32'h0;
		end else if (take) begin
			dual  <= (req_size == LSIMM_SZ_DUAL) && (req_op != LSIMM_OP_ADR);
			beats <= 2'h0;
		end else if (mem_valid) begin
			beats     <= beats + 2'h1;
			last_addr <= mem_addr;
		end
	end
	// ==========================================================
	// Properties.
	a_ofs_addr: assert property (
		ls && req_mode != LSIMM_MD_POST ##1 mem_valid |-> mem_addr == $past(ofs_a))
		else $error("offset address wrong");
	a_post_addr: assert property (
		ls && req_mode == LSIMM_MD_POST ##1 mem_valid |-> mem_addr == $past(req_base))
		else $error("post address wrong");
	a_beat_kind: assert property (
		ls ##1 mem_valid |-> mem_write == ($past(req_op) == LSIMM_OP_STORE)
		&& mem_size == (($past(req_size) == LSIMM_SZ_DUAL) ? LSIMM_SZ_WORD : $past(req_size)))
		else $error("beat kind wrong");
	a_word_data: assert property (
		ls && req_op == LSIMM_OP_STORE && req_size == LSIMM_SZ_WORD ##1 mem_valid
		|-> mem_wdata == $past(req_wdata)) else $error("store data wrong");
	a_dual_next: assert property (
		mem_done && dual && beats == 2'h1 |=> mem_valid && mem_addr == last_addr + DUAL_STEP)
		else $error("second beat wrong");
	a_adr_none: assert property (
		take && req_op == LSIMM_OP_ADR |=> !mem_valid && req_ready)
		else $error("address form touched memory");
	a_idx_range: assert property (
		ls && req_size != LSIMM_SZ_DUAL && req_mode != LSIMM_MD_OFFSET && req_imm > OFS_IDX_MAX
		|=> !mem_valid) else $error("indexed range not refused");
	a_sub_range: assert property (
		ls && req_size != LSIMM_SZ_DUAL && !req_add && req_imm > OFS_SUB_MAX |=> !mem_valid)
		else $error("negative range not refused");
	a_dual_range: assert property (
		ls && req_size == LSIMM_SZ_DUAL && (req_imm > OFS_DUAL_MAX || req_imm[1:0] != 2'h0)
		|=> !mem_valid) else $error("pair range not refused");
	a_one_flight: assert property (
		mem_valid |-> !req_ready) else $error("ready during access");
	a_ready_back: assert property (
		mem_done && !(dual && beats == 2'h1) |=> req_ready) else $error("ready not returned");
	a_req_hold: assert property (
		req_valid && !req_ready |=> req_valid) else $error("request dropped");
endmodule

/* File: tb/lsimm_tb.sv */
`timescale 1ns/1ps
module lsimm_tb;
	import lsimm_pkg::*;
	localparam logic [31:0] BASE = 32'h0000_2000;
	localparam logic [31:0] PCV  = 32'h0000_8000;
	logic clk, rst, i_valid, i_signed, i_add, i_blk, i_last, o_ready, o_reject, o_bad;
	lsimm_op_t i_op;
	lsimm_size_t i_size, o_mem_size;
	lsimm_mode_t i_mode;
	logic [11:0] i_imm;
	logic [3:0] i_rt, i_rt2, i_rn, res_reg, wb_reg, wbr, r_reg[2];
	logic [31:0] i_wdata, i_wdata2, pat, o_mem_addr, o_mem_wdata, i_mem_rdata;
	logic [31:0] res_data, wb_data, br_tgt, b_addr[2], b_wd[2], r_data[2], wbd, brt, e;
	logic o_mem_valid, o_mem_write, i_mem_done, res_v, wb_v, br_v, fault, b_wr[2];
	lsimm_size_t b_sz[2];
	int beat_n, res_n, wb_n, br_n, fault_n, rej_n, bad_n, err_count, checks_done;
	lsimm_if link();
	lsimm_iss u_lsimm_iss (.I_CLOCK(clk), .I_RESET(rst), .LINK(link), .I_VALID(i_valid),
		.I_OP(i_op), .I_SIZE(i_size), .I_SIGNED(i_signed), .I_MODE(i_mode), .I_ADD(i_add),
		.I_IMM(i_imm), .I_RT(i_rt), .I_RT2(i_rt2), .I_RN(i_rn), .I_BASE(BASE), .I_PC(PCV),
		.I_WDATA(i_wdata), .I_WDATA2(i_wdata2), .I_IN_BLOCK(i_blk), .I_BLOCK_LAST(i_last),
		.O_READY(o_ready), .O_REJECT(o_reject), .O_BAD_TARGET(o_bad),
		.O_MEM_VALID(o_mem_valid), .O_MEM_WRITE(o_mem_write), .O_MEM_ADDR(o_mem_addr),
		.O_MEM_SIZE(o_mem_size), .O_MEM_WDATA(o_mem_wdata), .I_MEM_DONE(i_mem_done),
		.I_MEM_RDATA(i_mem_rdata));
	lsimm_dev u_lsimm_dev (.I_CLOCK(clk), .I_RESET(rst), .LINK(link), .O_RES_VALID(res_v),
		.O_RES_REG(res_reg), .O_RES_DATA(res_data), .O_WB_VALID(wb_v), .O_WB_REG(wb_reg),
		.O_WB_DATA(wb_data), .O_BRANCH_VALID(br_v), .O_BRANCH_TARGET(br_tgt), .O_FAULT(fault));
	lsimm_props u_props (.I_CLOCK(clk), .I_RESET(rst), .req_valid(link.req_valid),
		.req_ready(link.req_ready), .req_op(link.req_op), .req_size(link.req_size),
		.req_mode(link.req_mode), .req_add(link.req_add), .req_imm(link.req_imm),
		.req_base(link.req_base), .req_wdata(link.req_wdata), .mem_valid(link.mem_valid),
		.mem_write(link.mem_write), .mem_addr(link.mem_addr), .mem_size(link.mem_size),
		.mem_wdata(link.mem_wdata), .mem_done(link.mem_done));
	// ==========================================================
	// Clock, memory responder and output monitor.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Read data outside a beat is inverted so that a late sample cannot pass.
	always @(negedge clk) begin
		i_mem_done <= o_mem_valid;
		i_mem_rdata <= o_mem_valid ? pat ^ o_mem_addr : ~(pat ^ o_mem_addr);
		if (o_mem_valid && beat_n < 2) begin
			b_addr[beat_n] = o_mem_addr;
			b_wd[beat_n] = o_mem_wdata;
			b_wr[beat_n] = o_mem_write;
			b_sz[beat_n] = o_mem_size;
		end
		if (res_v && res_n < 2) begin
			r_reg[res_n] = res_reg;
			r_data[res_n] = res_data;
		end
		if (wb_v) {wbr, wbd} = {wb_reg, wb_data};
		if (br_v) brt = br_tgt;
		beat_n += int'(o_mem_valid);
		res_n += int'(res_v);
		wb_n += int'(wb_v);
		br_n += int'(br_v);
		fault_n += int'(fault);
		rej_n += int'(o_reject);
		bad_n += int'(o_bad);
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		if (err_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// One instruction, run until both ends are idle again.
	task automatic issue(input lsimm_op_t op, input lsimm_size_t sz, input lsimm_mode_t md,
		input logic sg, input logic ad, input logic [11:0] imm, input logic [3:0] rt);
		int n;
		@(negedge clk);
		{beat_n, res_n, wb_n, br_n, fault_n, rej_n, bad_n} = '0;
		i_op = op;
		i_size = sz;
		i_mode = md;
		{i_signed, i_add, i_imm, i_rt} = {sg, ad, imm, rt};
		i_valid = 1'b1;
		@(negedge clk);
		i_valid = 1'b0;
		n = 1;
		while (!(n >= 3 && o_ready && link.req_ready && !link.req_valid && !o_mem_valid)
			&& n < 40) begin
			@(negedge clk);
			n++;
		end
		check("idle", 32'(n < 40), 32'h1);
		@(negedge clk);
	endtask
	function automatic logic [31:0] ofs(input logic ad, input logic [11:0] imm);
		return ad ? BASE + {20'h0, imm} : BASE - {20'h0, imm};
	endfunction
	// ==========================================================
	// Scenarios.
	task automatic t_adr();
		for (int a = 0; a < 2; a++) begin
			issue(LSIMM_OP_ADR, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 1'b0, a[0], 12'hFFF, 4'h1);
			check("adr sum", r_data[0], a ? PCV + 32'hFFF : PCV - 32'hFFF);
			check("adr reg", {28'h0, r_reg[0]}, 32'h1);
			check("adr count", res_n, 1);
			check("adr beats", beat_n, 0);
			check("adr side", wb_n + br_n + fault_n, 0);
		end
	endtask
	task automatic t_modes();
		for (int m = 0; m < 3; m++) for (int a = 0; a < 2; a++) begin
			issue(LSIMM_OP_LOAD, LSIMM_SZ_WORD, lsimm_mode_t'(m), 1'b0, a[0], 12'h0F0, 4'h2);
			e = (m == 2) ? BASE : ofs(a[0], 12'h0F0);
			check("ld addr", b_addr[0], e);
			check("ld data", r_data[0], pat ^ e);
			check("wb count", wb_n, int'(m != 0));
			if (m != 0) check("wb value", wbd, ofs(a[0], 12'h0F0));
			if (m != 0) check("wb reg", {28'h0, wbr}, 32'h5);
		end
		issue(LSIMM_OP_LOAD, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 1'b0, 1'b1, 12'h000, 4'h2);
		check("no offset", b_addr[0], BASE);
	endtask
	task automatic t_narrow();
		pat = 32'h1234_8F80;
		for (int s = 0; s < 2; s++) for (int g = 0; g < 2; g++) begin
			issue(LSIMM_OP_LOAD, lsimm_size_t'(s), LSIMM_MD_OFFSET, g[0], 1'b1, 12'h0, 4'h2);
			e = pat ^ BASE;
			if (s == 0) e = g ? {{24{e[7]}}, e[7:0]} : {24'h0, e[7:0]};
			else e = g ? {{16{e[15]}}, e[15:0]} : {16'h0, e[15:0]};
			check("extend", r_data[0], e);
		end
	endtask
	task automatic t_pair();
		issue(LSIMM_OP_LOAD, LSIMM_SZ_DUAL, LSIMM_MD_PRE, 1'b0, 1'b1, 12'h3FC, 4'h2);
		e = BASE + 32'h3FC;
		check("pair beat1", b_addr[1], e + 32'h4);
		check("pair data2", r_data[1], pat ^ (e + 32'h4));
		check("pair reg2", {28'h0, r_reg[1]}, 32'h3);
		check("pair wb", wbd, e);
		issue(LSIMM_OP_STORE, LSIMM_SZ_DUAL, LSIMM_MD_POST, 1'b0, 1'b0, 12'h3FC, 4'h6);
		check("st addr", b_addr[1], BASE + 32'h4);
		check("st data2", b_wd[1], i_wdata2);
		check("st wb", wbd, BASE - 32'h3FC);
		issue(LSIMM_OP_STORE, LSIMM_SZ_BYTE, LSIMM_MD_OFFSET, 1'b0, 1'b1, 12'h010, 4'h6);
		check("byte kind", {29'h0, b_wr[0], b_sz[0]}, {29'h0, 1'b1, LSIMM_SZ_BYTE});
		check("byte data", {24'h0, b_wd[0][7:0]}, {24'h0, i_wdata[7:0]});
		check("byte wb", wb_n, 0);
	endtask
	task automatic rng(input lsimm_op_t op, input lsimm_size_t sz, input lsimm_mode_t md,
		input logic ad, input logic [11:0] imm, input int ok);
		issue(op, sz, md, 1'b0, ad, imm, 4'h2);
		check("range fault", fault_n, 1 - ok);
		check("range beats", beat_n, ok * ((sz == LSIMM_SZ_DUAL) ? 2 : 1));
	endtask
	task automatic t_range();
		rng(LSIMM_OP_LOAD, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 1'b1, 12'hFFF, 1);
		rng(LSIMM_OP_LOAD, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 1'b0, 12'h100, 0);
		rng(LSIMM_OP_LOAD, LSIMM_SZ_HALF, LSIMM_MD_PRE, 1'b1, 12'h100, 0);
		rng(LSIMM_OP_STORE, LSIMM_SZ_WORD, LSIMM_MD_POST, 1'b0, 12'h0FF, 1);
		rng(LSIMM_OP_LOAD, LSIMM_SZ_DUAL, LSIMM_MD_PRE, 1'b1, 12'h3FE, 0);
		rng(LSIMM_OP_LOAD, LSIMM_SZ_DUAL, LSIMM_MD_POST, 1'b0, 12'h400, 0);
	endtask
	task automatic rj(input lsimm_op_t op, input lsimm_size_t sz, input lsimm_mode_t md,
		input logic [3:0] rt, input logic [3:0] rn, input logic [1:0] blk, input int exp);
		{i_rn, i_blk, i_last} = {rn, blk};
		issue(op, sz, md, 1'b0, 1'b1, 12'h0, rt);
		check("reject", rej_n, exp);
		if (exp == 1) check("reject beats", beat_n, 0);
		{i_rn, i_blk, i_last} = {4'h5, 2'h0};
	endtask
	task automatic t_reject();
		rj(LSIMM_OP_ADR, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 4'hD, 4'h5, 2'h0, 1);
		rj(LSIMM_OP_LOAD, LSIMM_SZ_BYTE, LSIMM_MD_OFFSET, 4'hF, 4'h5, 2'h0, 1);
		rj(LSIMM_OP_LOAD, LSIMM_SZ_DUAL, LSIMM_MD_OFFSET, 4'h3, 4'h5, 2'h0, 1);
		rj(LSIMM_OP_LOAD, LSIMM_SZ_WORD, LSIMM_MD_PRE, 4'h5, 4'h5, 2'h0, 1);
		rj(LSIMM_OP_STORE, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 4'h2, 4'hF, 2'h0, 1);
		rj(LSIMM_OP_LOAD, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 4'hF, 4'h5, 2'h2, 1);
		rj(LSIMM_OP_LOAD, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 4'hF, 4'h5, 2'h3, 0);
	endtask
	task automatic t_branch();
		for (int b = 0; b < 2; b++) begin
			pat = 32'h0000_1234 | 32'(b);
			issue(LSIMM_OP_LOAD, LSIMM_SZ_WORD, LSIMM_MD_OFFSET, 1'b0, 1'b1, 12'h0, 4'hF);
			check("branch", br_n, 1);
			check("target", brt, (pat ^ BASE) & 32'hFFFF_FFFE);
			check("bad target", bad_n, 1 - b);
			check("no result", res_n, 0);
		end
	endtask
	// ==========================================================
	// Main sequence and watchdog.
	initial begin
		{i_valid, i_signed, i_add, i_blk, i_last} = '0;
		i_op = LSIMM_OP_ADR;
		i_size = LSIMM_SZ_BYTE;
		i_mode = LSIMM_MD_OFFSET;
		{i_imm, i_rt} = '0;
		{i_rt2, i_rn, i_wdata, i_wdata2} = {4'h3, 4'h5, 32'hA5C3_1E97, 32'h5A3C_E168};
		{err_count, checks_done} = '0;
		pat = 32'h0F1E_2D3C;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_adr();
		t_modes();
		t_narrow();
		t_pair();
		t_range();
		t_reject();
		t_branch();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done();
	end
endmodule
